// ### core/aseq_ctrl.sv
/*
 * Conversion sequencing for a sigma-delta ADC: sequence and extra
 * conversion control, result capture, end-of-conversion flag, DMA
 * triggers and the extra-conversion interrupt.
 * Assumes the register port and the filter's result run on clock_i.
 */
`timescale 1ns/1ps
`include "aseq_defines.svh"

module aseq_ctrl #(
	parameter int CONV_PERIOD_NS = `ASEQ_CONV_PERIOD_NS,
	parameter int CNT_W          = 20
) (
	// Clock and reset
	input  wire logic                          clock_i,
	input  wire logic                          sys_rst_i,
	// Register port
	input  wire logic [7:0]                    reg_addr_i,
	input  wire logic [7:0]                    reg_wdata_i,
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	output logic      [7:0]                    reg_rdata_o,
	// Multiplexer, reference and filter
	output logic      [3:0]                    mux_channel_o,
	output logic      [1:0]                    ref_select_o,
	output logic      [1:0]                    decimation_o,
	output logic                               conv_start_o,
	output logic                               conv_busy_o,
	input  wire logic [13:0]                   result_i,
	// DMA and interrupt
	output logic                               dma_all_o,
	output logic      [`ASEQ_DMA_CHANNELS-1:0] dma_chan_o,
	output logic                               irq_o
);

	// ****************************************
	// Declarations
	// ****************************************
	aseq_pkg::aseq_ctrl_t  seq_reg;
	aseq_pkg::aseq_ctrl_t  ext_reg;
	aseq_pkg::aseq_state_t state_reg;
	aseq_pkg::aseq_state_t state_next;
	logic [3:0]            cur_ch_reg;
	logic [3:0]            last_ch_reg;
	logic [CNT_W-1:0]      cnt_reg;
	logic                  ext_pend_reg;
	logic [3:0]            res_ch_reg;
	logic [13:0]           res_reg;
	logic                  eoc_reg;
	logic                  irq_stat_reg;
	logic                  irq_en_reg;
	logic [7:0]            rdata_reg;
	logic                  conv_start_reg;
	logic                  dma_all_reg;
	logic [3:0]            mux_reg;
	logic [1:0]            ref_reg;
	logic [1:0]            dec_reg;
	logic                  launch;
	logic [3:0]            launch_ch;
	logic [1:0]            launch_ref;
	logic [1:0]            launch_dec;
	logic                  conv_done;
	logic                  seq_more;
	logic                  wr_seq;
	logic                  wr_ext;
	logic                  wr_run;
	logic                  start_seq;
	logic                  rd_high;
	logic [3:0]            first_ch;

	// Full conversion length in system clocks for a decimation code
	function automatic logic [CNT_W-1:0] conv_cycles(input logic [1:0] dec);
		int n;
		n = ((`ASEQ_DEC_BASE << dec) + `ASEQ_SETTLE_PERIODS) * CONV_PERIOD_NS
			/ `ASEQ_CLK_PERIOD_NS;
		return CNT_W'(n);
	endfunction

	// ****************************************
	// Register decode
	// ****************************************
	assign wr_seq    = reg_wr_i && (reg_addr_i == `ASEQ_OFS_SEQ_CTRL);
	assign wr_ext    = reg_wr_i && (reg_addr_i == `ASEQ_OFS_EXT_CTRL);
	assign wr_run    = reg_wr_i && (reg_addr_i == `ASEQ_OFS_RUN_CTRL);
	assign start_seq = wr_run && reg_wdata_i[`ASEQ_RUN_START_BIT];
	assign rd_high   = reg_rd_i && (reg_addr_i == `ASEQ_OFS_RES_HIGH);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			seq_reg <= `ASEQ_RST_SEQ_CTRL;
		end else if (wr_seq) begin
			seq_reg <= reg_wdata_i;
		end
	end

	// Channel field clears on extra done unless a new request is waiting
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_reg <= `ASEQ_RST_EXT_CTRL;
		end else if (wr_ext) begin
			ext_reg <= reg_wdata_i;
		end else if (conv_done && state_reg == aseq_pkg::ASEQ_EXTRA && !ext_pend_reg) begin
			ext_reg.chan <= 4'h0;
		end
	end

	// Only a write of the extra field arms an extra conversion
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_pend_reg <= 1'b0;
		end else if (wr_ext) begin
			ext_pend_reg <= 1'b1;
		end else if (launch && state_next == aseq_pkg::ASEQ_EXTRA) begin
			ext_pend_reg <= 1'b0;
		end
	end

	// ****************************************
	// Sequencing
	// ****************************************
	always_comb begin
		if (seq_reg.chan <= `ASEQ_CH_SE_LAST) begin
			first_ch = 4'h0;
		end else if (seq_reg.chan <= `ASEQ_CH_DIFF_LAST) begin
			first_ch = `ASEQ_CH_DIFF_FIRST;
		end else begin
			first_ch = seq_reg.chan;
		end
	end

	assign conv_done = (state_reg != aseq_pkg::ASEQ_IDLE) && (cnt_reg == CNT_W'(1));
	assign seq_more  = (state_reg == aseq_pkg::ASEQ_SEQ) && (cur_ch_reg != last_ch_reg)
		&& (last_ch_reg <= `ASEQ_CH_DIFF_LAST);

	always_comb begin
		launch     = 1'b0;
		state_next = state_reg;
		launch_ch  = cur_ch_reg;
		launch_ref = seq_reg.refsel;
		launch_dec = seq_reg.decsel;
		unique case (state_reg)
			aseq_pkg::ASEQ_IDLE: begin
				if (start_seq) begin
					launch     = 1'b1;
					state_next = aseq_pkg::ASEQ_SEQ;
					launch_ch  = first_ch;
				end else if (ext_pend_reg) begin
					launch     = 1'b1;
					state_next = aseq_pkg::ASEQ_EXTRA;
					launch_ch  = ext_reg.chan;
					launch_ref = ext_reg.refsel;
					launch_dec = ext_reg.decsel;
				end
			end
			aseq_pkg::ASEQ_SEQ: begin
				if (conv_done && seq_more) begin
					launch    = 1'b1;
					launch_ch = cur_ch_reg + 4'h1;
				end else if (conv_done && ext_pend_reg) begin
					launch     = 1'b1;
					state_next = aseq_pkg::ASEQ_EXTRA;
					launch_ch  = ext_reg.chan;
					launch_ref = ext_reg.refsel;
					launch_dec = ext_reg.decsel;
				end else if (conv_done) begin
					state_next = aseq_pkg::ASEQ_IDLE;
				end
			end
			aseq_pkg::ASEQ_EXTRA: begin
				if (conv_done) begin
					state_next = aseq_pkg::ASEQ_IDLE;
				end
			end
			default: begin
				state_next = aseq_pkg::ASEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= aseq_pkg::ASEQ_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Sequence end is latched so a mid-sequence write cannot derail the sweep
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			last_ch_reg <= 4'h0;
		end else if (start_seq && state_reg == aseq_pkg::ASEQ_IDLE) begin
			last_ch_reg <= seq_reg.chan;
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_reg <= '0;
		end else if (launch) begin
			cnt_reg <= conv_cycles(launch_dec);
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - CNT_W'(1);
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cur_ch_reg     <= 4'h0;
			mux_reg        <= 4'h0;
			ref_reg        <= 2'b00;
			dec_reg        <= 2'b00;
			conv_start_reg <= 1'b0;
		end else begin
			conv_start_reg <= launch;
			if (launch) begin
				cur_ch_reg <= launch_ch;
				mux_reg    <= launch_ch;
				ref_reg    <= launch_ref;
				dec_reg    <= launch_dec;
			end
		end
	end

	// ****************************************
	// Results and end-of-conversion flag
	// ****************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			res_reg    <= '0;
			res_ch_reg <= `ASEQ_RST_RES_CH;
		end else if (conv_done) begin
			res_reg    <= result_i;
			res_ch_reg <= cur_ch_reg;
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			eoc_reg <= 1'b0;
		end else if (conv_done) begin
			eoc_reg <= 1'b1;
		end else if (rd_high) begin
			eoc_reg <= 1'b0;
		end
	end

	// ****************************************
	// DMA triggers
	// ****************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dma_all_reg <= 1'b0;
		end else begin
			dma_all_reg <= conv_done && state_reg == aseq_pkg::ASEQ_SEQ;
		end
	end

	for (genvar i = 0; i < `ASEQ_DMA_CHANNELS; i++) begin : g_dma
		always_ff @(posedge clock_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				dma_chan_o[i] <= 1'b0;
			end else begin
				dma_chan_o[i] <= conv_done && state_reg == aseq_pkg::ASEQ_SEQ
					&& cur_ch_reg == 4'(i);
			end
		end
	end

	// ****************************************
	// Interrupt
	// ****************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_stat_reg <= 1'b0;
		end else if (conv_done && state_reg == aseq_pkg::ASEQ_EXTRA) begin
			irq_stat_reg <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == `ASEQ_OFS_IRQ_CLR
			&& reg_wdata_i[`ASEQ_IRQ_EXT_BIT]) begin
			irq_stat_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_en_reg <= 1'b0;
		end else if (reg_wr_i && reg_addr_i == `ASEQ_OFS_IRQ_EN) begin
			irq_en_reg <= reg_wdata_i[`ASEQ_IRQ_EXT_BIT];
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`ASEQ_OFS_SEQ_CTRL: rdata_reg <= {seq_reg.refsel, seq_reg.decsel,
					res_ch_reg + 4'h1};
				`ASEQ_OFS_EXT_CTRL: rdata_reg <= ext_reg;
				`ASEQ_OFS_RES_LOW:  rdata_reg <= {res_reg[5:0], 2'b00};
				`ASEQ_OFS_RES_HIGH: rdata_reg <= res_reg[13:6];
				`ASEQ_OFS_RUN_CTRL: rdata_reg <= {eoc_reg, state_reg != aseq_pkg::ASEQ_IDLE,
					6'h00};
				`ASEQ_OFS_IRQ_STAT: rdata_reg <= {7'h00, irq_stat_reg};
				`ASEQ_OFS_IRQ_EN:   rdata_reg <= {7'h00, irq_en_reg};
				default:            rdata_reg <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata_o   = rdata_reg;
	assign mux_channel_o = mux_reg;
	assign ref_select_o  = ref_reg;
	assign decimation_o  = dec_reg;
	assign conv_start_o  = conv_start_reg;
	assign conv_busy_o   = state_reg != aseq_pkg::ASEQ_IDLE;
	assign dma_all_o     = dma_all_reg;
	assign irq_o         = irq_stat_reg & irq_en_reg;

endmodule

// ### inc/aseq_defines.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * ADC sequence and extra conversion control block.
 * Assumes an 8-bit register port with byte addresses.
 */
`ifndef ASEQ_DEFINES_SVH
`define ASEQ_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ASEQ_OFS_SEQ_CTRL   8'hb5
`define ASEQ_OFS_EXT_CTRL   8'hb6
`define ASEQ_OFS_RES_LOW    8'hba
`define ASEQ_OFS_RES_HIGH   8'hbb
`define ASEQ_OFS_RUN_CTRL   8'hc0
`define ASEQ_OFS_IRQ_STAT   8'hc1
`define ASEQ_OFS_IRQ_CLR    8'hc2
`define ASEQ_OFS_IRQ_EN     8'hc3

// ****************************************
// Field positions
// ****************************************
`define ASEQ_RUN_START_BIT  0
`define ASEQ_RUN_BUSY_BIT   6
`define ASEQ_RUN_EOC_BIT    7
`define ASEQ_IRQ_EXT_BIT    0
`define ASEQ_CH_SE_LAST     4'h7
`define ASEQ_CH_DIFF_FIRST  4'h8
`define ASEQ_CH_DIFF_LAST   4'hb
`define ASEQ_DMA_CHANNELS   8

// ****************************************
// Reset values
// ****************************************
`define ASEQ_RST_SEQ_CTRL   8'h10
`define ASEQ_RST_EXT_CTRL   8'h00
`define ASEQ_RST_RES_CH     4'hf

// ****************************************
// Timing
// ****************************************
`define ASEQ_CLK_PERIOD_NS  4
`define ASEQ_CONV_PERIOD_NS 250
`define ASEQ_SETTLE_PERIODS 16
`define ASEQ_DEC_BASE       64

`endif

// ### inc/aseq_pkg.sv
/*
 * Types of the ADC sequence and extra conversion control block.
 * Assumes aseq_defines.svh holds every offset, field position and timing figure; the state codes are here.
 */
package aseq_pkg;

	// ****************************************
	// Control register layout
	// ****************************************
	typedef struct packed {
		logic [1:0] refsel;
		logic [1:0] decsel;
		logic [3:0] chan;
	} aseq_ctrl_t;

	// ****************************************
	// Converter states
	// ****************************************
	typedef enum logic [1:0] {
		ASEQ_IDLE  = 2'b00,
		ASEQ_SEQ   = 2'b01,
		ASEQ_EXTRA = 2'b10
	} aseq_state_t;

endpackage

// ### testbench/aseq_ctrl_asserts.sv
/* Port checker for aseq_ctrl, bound into it.
   Assumes one clock domain and the shortened conversion period. */
`timescale 1ns/1ps
`include "aseq_defines.svh"
module aseq_ctrl_asserts #(
	parameter int CONV_PERIOD_NS = `ASEQ_CONV_PERIOD_NS
) (
	// Clock and reset
	input wire logic       clock_i,
	input wire logic       sys_rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	// Converter side
	input wire logic [3:0] mux_channel_o,
	input wire logic [1:0] ref_select_o,
	input wire logic [1:0] decimation_o,
	input wire logic       conv_start_o,
	input wire logic       conv_busy_o,
	input wire logic       dma_all_o,
	input wire logic [7:0] dma_chan_o,
	input wire logic       irq_o
);
	logic [7:0] seq_reg;
	logic [7:0] seq_first;
	logic [7:0] launch;
	int         cnt_reg;
	int         n_exp;
	logic       ext_idle;
	logic       run_idle;

	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	// Shadow of the sequence settings, since reads of it show a result channel
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			seq_reg <= `ASEQ_RST_SEQ_CTRL;
		end else if (reg_wr_i && reg_addr_i == `ASEQ_OFS_SEQ_CTRL) begin
			seq_reg <= reg_wdata_i;
		end
	end
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_reg <= 0;
		end else if (conv_start_o) begin
			cnt_reg <= 1;
		end else if (conv_busy_o) begin
			cnt_reg <= cnt_reg + 1;
		end
	end
	assign seq_first[7:4] = seq_reg[7:4];
	assign seq_first[3:0] = (seq_reg[3:0] <= `ASEQ_CH_SE_LAST) ? 4'h0 :
		(seq_reg[3:0] <= `ASEQ_CH_DIFF_LAST) ? `ASEQ_CH_DIFF_FIRST : seq_reg[3:0];
	assign launch = {ref_select_o, decimation_o, mux_channel_o};
	assign n_exp = ((`ASEQ_DEC_BASE << decimation_o) + `ASEQ_SETTLE_PERIODS)
		* CONV_PERIOD_NS / 4;
	assign ext_idle = reg_wr_i && reg_addr_i == `ASEQ_OFS_EXT_CTRL && !conv_busy_o;
	assign run_idle = reg_wr_i && reg_addr_i == `ASEQ_OFS_RUN_CTRL
		&& reg_wdata_i[0] && !conv_busy_o;

	property p_ext_launch; ext_idle |-> ##2 conv_start_o && launch == $past(reg_wdata_i, 2); endproperty
	a_ext_launch: assert property (p_ext_launch) else $error("extra launch");
	// A start launches at its own write edge, one cycle ahead of an extra request
	property p_seq_launch; run_idle |-> ##1 conv_start_o && launch == $past(seq_first, 1); endproperty
	a_seq_launch: assert property (p_seq_launch) else $error("sequence launch");
	property p_start_gap; conv_start_o |=> !conv_start_o [*8]; endproperty
	a_start_gap: assert property (p_start_gap) else $error("start too soon");
	property p_busy_len; $fell(conv_busy_o) |-> cnt_reg >= n_exp - 3 && cnt_reg <= n_exp + 3; endproperty
	a_busy_len: assert property (p_busy_len) else $error("conversion length");
	property p_busy_rise; $rose(conv_busy_o) |-> conv_start_o; endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy without start");
	property p_dma_chan; dma_chan_o != 8'h00 |-> dma_all_o; endproperty
	a_dma_chan: assert property (p_dma_chan) else $error("channel trigger alone");
	property p_dma_onehot; $onehot0(dma_chan_o); endproperty
	a_dma_onehot: assert property (p_dma_onehot) else $error("two channel triggers");
	property p_irq_seq; dma_all_o |-> !$rose(irq_o); endproperty
	a_irq_seq: assert property (p_irq_seq) else $error("interrupt on sequence");
endmodule

bind aseq_ctrl aseq_ctrl_asserts #(.CONV_PERIOD_NS(CONV_PERIOD_NS)) u_asserts (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .mux_channel_o(mux_channel_o),
	.ref_select_o(ref_select_o), .decimation_o(decimation_o), .conv_start_o(conv_start_o),
	.conv_busy_o(conv_busy_o), .dma_all_o(dma_all_o), .dma_chan_o(dma_chan_o), .irq_o(irq_o)
);

// ### testbench/aseq_afe_model.sv
/* Front-end model: multiplexer channel and filter result.
   Assumes the result is sampled at the end of each conversion. */
`timescale 1ns/1ps
module aseq_afe_model (
	// Clock
	input  wire logic        clock_i,
	// Converter control
	input  wire logic        conv_start_i,
	input  wire logic [3:0]  mux_channel_i,
	// Filter result
	output logic      [13:0] result_o
);
	initial result_o = 14'h0000;
	// A fresh value per conversion, so a stale capture shows
	always @(posedge clock_i) begin
		if (conv_start_i) begin
			result_o <= {mux_channel_i, 10'($urandom)};
		end
	end
endmodule

// ### testbench/testbench.sv
/* Bench for aseq_ctrl: register tasks, a queue of expected launches.
   Assumes conversions shortened by CONV_PERIOD_NS of 8. */
`timescale 1ns/1ps
`include "aseq_defines.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", n, e, s); end end
module testbench;
	localparam logic [7:0] SEQ = `ASEQ_OFS_SEQ_CTRL;
	localparam logic [7:0] EXT = `ASEQ_OFS_EXT_CTRL;
	localparam logic [7:0] RUN = `ASEQ_OFS_RUN_CTRL;
	localparam logic [7:0] STA = `ASEQ_OFS_IRQ_STAT;
	logic        clock_i, sys_rst_i, reg_wr_i, reg_rd_i, conv_start_o;
	logic        conv_busy_o, dma_all_o, irq_o;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, dma_chan_o, ev, ev2, rv;
	logic [3:0]  mux_channel_o, last_ch;
	logic [1:0]  ref_select_o, decimation_o;
	logic [13:0] result_i;
	logic [7:0]  exp_q[$];
	logic [3:0]  lasts[6] = '{4'h7, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
	int          mismatches, total_checks, dma_cnt, cycles;

	aseq_ctrl #(.CONV_PERIOD_NS(8)) u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mux_channel_o(mux_channel_o),
		.ref_select_o(ref_select_o), .decimation_o(decimation_o),
		.conv_start_o(conv_start_o), .conv_busy_o(conv_busy_o), .result_i(result_i),
		.dma_all_o(dma_all_o), .dma_chan_o(dma_chan_o), .irq_o(irq_o));
	aseq_afe_model u_afe (.clock_i(clock_i), .conv_start_i(conv_start_o),
		.mux_channel_i(mux_channel_o), .result_o(result_i));

	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (3) @(posedge clock_i);
		while (conv_busy_o === 1'b1 && n < 4000) begin
			@(posedge clock_i);
			n++;
		end
		// Let the trigger monitor count the last pulse of this edge first
		@(negedge clock_i);
		`CHK("idle", 1'b0, conv_busy_o)
	endtask
	task automatic extra(input logic [7:0] c, input logic en);
		exp_q.push_back(c);
		wr(EXT, c);
		wait_idle();
		rd(`ASEQ_OFS_RES_HIGH, rv);
		`CHK("res_high", result_i[13:6], rv)
		rd(`ASEQ_OFS_RES_LOW, rv);
		`CHK("res_low", {result_i[5:0], 2'b00}, rv)
		rd(EXT, rv);
		`CHK("ext_clear", {c[7:4], 4'h0}, rv)
		rd(STA, rv);
		`CHK("irq_stat", 8'h01, rv)
		`CHK("irq", en, irq_o)
		wr(`ASEQ_OFS_IRQ_CLR, 8'h01);
		@(posedge clock_i);
		`CHK("irq_clr", 1'b0, irq_o)
	endtask
	task automatic seq(input logic [7:0] c, input logic xtra);
		int f, d0;
		f = (c[3:0] <= 4'h7) ? 0 : (c[3:0] <= 4'hb) ? 8 : int'(c[3:0]);
		d0 = dma_cnt;
		for (int k = f; k <= int'(c[3:0]); k++) begin
			exp_q.push_back({c[7:4], 4'(k)});
		end
		wr(SEQ, c);
		wr(RUN, 8'h01);
		// A second start and an extra request while running
		if (xtra) begin
			repeat (3) @(posedge clock_i);
			exp_q.push_back(8'h35);
			wr(EXT, 8'h35);
			wr(RUN, 8'h01);
		end
		wait_idle();
		`CHK("dma_count", int'(c[3:0]) - f + 1, dma_cnt - d0)
		rd(SEQ, rv);
		`CHK("seq_read", {c[7:4], (xtra ? 4'h5 : c[3:0]) + 4'h1}, rv)
		rd(STA, rv);
		`CHK("irq_stat", {7'h00, xtra}, rv)
		rd(RUN, rv);
		`CHK("eoc_set", 1'b1, rv[7])
		rd(`ASEQ_OFS_RES_HIGH, rv);
		rd(RUN, rv);
		`CHK("eoc_clear", 1'b0, rv[7])
		wr(`ASEQ_OFS_IRQ_CLR, 8'h01);
		$display("test sequence %h done", c);
	endtask

	// Launch order model and trigger monitor
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
		if (dma_all_o === 1'b1) begin
			dma_cnt++;
			`CHK("dma_chan", (last_ch < 4'h8) ? 8'h01 << last_ch : 8'h00, dma_chan_o)
		end
		if (conv_start_o === 1'b1) begin
			ev2 = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
			`CHK("launch", ev2, {ref_select_o, decimation_o, mux_channel_o})
			last_ch = mux_channel_o;
		end
	end

	initial begin
		sys_rst_i = 1'b1;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		void'($urandom(60));
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		rd(SEQ, rv);
		`CHK("seq_reset", 8'h10, rv)
		rd(EXT, rv);
		`CHK("ext_reset", 8'h00, rv)
		rd(8'h00, rv);
		`CHK("unmapped", 8'h00, rv)
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			ev = {i[1:0], i[1:0], (i == 3) ? 4'hf : 4'($urandom)};
			wr(`ASEQ_OFS_IRQ_EN, {7'h00, i[0]});
			extra(ev, i[0]);
		end
		$display("test extra done");
		foreach (lasts[k]) begin
			seq({k[1:0], k[1:0], lasts[k]}, 1'b0);
		end
		seq(8'h42, 1'b1);
		report_and_stop();
	end
endmodule
